// file: verilog/tac_pkg.sv
// tac_pkg: constants for the temperature adc conversion and register block
package tac_pkg;

  // ************************************************************
  // register pointer codes (low three pointer bits)
  // ************************************************************
  localparam logic [2:0] PTR_TEMP_RESULT = 3'h0; // temperature_result, read only
  localparam logic [2:0] PTR_OPER_CFG = 3'h1; // operating_configuration
  localparam logic [2:0] PTR_HYST_SET = 3'h2; // hysteresis_setpoint
  localparam logic [2:0] PTR_OTEMP_SET = 3'h3; // over_temp_setpoint
  localparam logic [2:0] PTR_VOLT_RESULT = 3'h4; // voltage_conversion_result, read only
  localparam logic [2:0] PTR_SEC_CFG = 3'h5; // secondary_configuration
  localparam int PTR_SEL_W = 3; // decoded pointer bits

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CFG_CHAN_LSB = 5; // channel select, bits 7..5
  localparam int CFG_FQ_LSB = 3; // fault queue, bits 4..3
  localparam int CFG_POL_BIT = 2; // indicator polarity, 1 = active high
  localparam int CFG_INT_BIT = 1; // 1 = interrupt mode, 0 = comparator
  localparam int CFG_SHDN_BIT = 0; // shutdown
  localparam int SEC_PIN_MODE_BIT = 7; // 1 = start pin only
  localparam int SEC_TEST_BIT = 6; // filter test bit, stored only
  localparam int RES_W = 10; // conversion code width
  localparam int SET_W = 9; // setpoint width

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] OPER_CFG_RST = 8'h00;
  localparam logic [7:0] SEC_CFG_RST = 8'h00;
  localparam logic [8:0] HYST_SET_RST = 9'h096; // plain default, 75 C
  localparam logic [8:0] OTEMP_SET_RST = 9'h0A0; // plain default, 80 C
  localparam logic [2:0] CHAN_TEMP = 3'h0; // temperature_channel code

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int HOLD_DELAY_NS = 3000; // wait after an access before hold
  localparam int VOLT_CONV_NS = 15000; // voltage channel conversion
  localparam int TEMP_CONV_NS = 30000; // temperature channel conversion
  localparam int AUTO_PERIOD_US = 355; // automatic interval
  localparam int HOLD_DELAY_CYC = (HOLD_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int VOLT_CONV_CYC = (VOLT_CONV_NS * CLK_MHZ) / 1000;
  localparam int TEMP_CONV_CYC = (TEMP_CONV_NS * CLK_MHZ) / 1000;
  localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_US * CLK_MHZ;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV
  } tac_state_t;

endpackage

// file: verilog/tac_core.sv
// tac_core: conversion sequencer, register bank and over-temperature logic
//
// Contract
// - start pin falling edge holds, starts conversion
// - auto mode converts after each serial access that ends while idle
// - auto mode waits 3 us after an access before hold
// - result after 15 us voltage, 30 us temperature
// - reference amplifier powered only during conversion
// - grounded reference input selects internal reference
// - six data registers plus 8-bit pointer
// - first written byte loads pointer, rest data
// - only low three pointer bits decoded
// - pointer codes map to the six registers
// - temperature 16-bit read only, left justified
// - temperature is 10-bit two's complement
// - configuration fields: channel, queue, polarity, mode
// - configuration bit 0 is shutdown, resets zero
// - channel codes select temperature or voltage inputs
// - fault queue codes give 1,2,4,6 faults
// - secondary bit 7 picks auto or pin mode
// - over-temperature from temperature code versus setpoint
module tac_core #(
  parameter int AUTO_PERIOD = tac_pkg::AUTO_PERIOD_CYC // automatic interval in cycles
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I, // low freezes all state
  input wire logic CONVERSION_START_N_I, // start pin, asynchronous
  input wire logic REFERENCE_INPUT_GND_I, // pin level: reference input grounded
  input wire logic ACC_ACTIVE_I, // serial access in progress
  input wire logic WR_VALID_I, // one written byte
  input wire logic WR_FIRST_I, // this byte is the first of a write
  input wire logic [7:0] WR_DATA_I,
  input wire logic RD_REQ_I, // request next read byte
  input wire logic [9:0] ADC_CODE_I, // converter code, valid at conversion end
  output logic [7:0] RD_DATA_O,
  output logic RD_VALID_O,
  output logic TRACK_HOLD_O, // 1 = hold
  output logic CONV_BUSY_O,
  output logic REF_AMP_ON_O,
  output logic INT_REF_EN_O,
  output logic [2:0] CHANNEL_O,
  output logic OTI_OUT_O, // open drain data, always low
  output logic OTI_OE_N_O // low while pulling the pin down
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (AUTO_PERIOD < tac_pkg::TEMP_CONV_CYC + 2 || AUTO_PERIOD > 65535) begin : g_bad_period
    $error("AUTO_PERIOD outside 16-bit counter or shorter than a conversion");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] start_sync_q; // [0] feeds only [1]
  logic start_prev_q; // delayed copy for edge detect
  logic [1:0] refgnd_sync_q; // [0] feeds only [1]
  logic acc_prev_q; // access level last cycle

  // two flops per pin, then edge history
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      start_sync_q <= 2'b11;
      start_prev_q <= 1'b1;
      refgnd_sync_q <= 2'b00;
      acc_prev_q <= 1'b0;
    end else if (CE_I) begin
      start_sync_q <= {start_sync_q[0], CONVERSION_START_N_I};
      start_prev_q <= start_sync_q[1];
      refgnd_sync_q <= {refgnd_sync_q[0], REFERENCE_INPUT_GND_I};
      acc_prev_q <= ACC_ACTIVE_I;
    end
  end

  wire start_fall = start_prev_q & ~start_sync_q[1]; // pin falling edge
  wire acc_end = acc_prev_q & ~ACC_ACTIVE_I; // access just finished
  wire acc_begin = ~acc_prev_q & ACC_ACTIVE_I; // access just opened

  // ************************************************************
  // register bank
  // ************************************************************
  logic [7:0] ptr_q; // register pointer, all 8 bits stored
  logic [7:0] cfg_q; // operating_configuration
  logic [7:0] sec_q; // secondary_configuration
  logic [8:0] hyst_q; // hysteresis_setpoint, 9 msbs
  logic [8:0] otemp_q; // over_temp_setpoint, 9 msbs
  logic [9:0] temp_res_q; // temperature_result code
  logic [9:0] volt_res_q; // voltage_conversion_result code
  logic wbyte_q; // 0 = next data byte is msb, 1 = lsb
  logic rbyte_q; // 0 = next read byte is msb, 1 = lsb

  wire [2:0] sel = ptr_q[tac_pkg::PTR_SEL_W-1:0];
  wire wr_ptr = WR_VALID_I & WR_FIRST_I;
  wire wr_dat = WR_VALID_I & ~WR_FIRST_I;
  wire wr_cfg = wr_dat & (sel == tac_pkg::PTR_OPER_CFG) & ~wbyte_q;
  wire wr_sec = wr_dat & (sel == tac_pkg::PTR_SEC_CFG) & ~wbyte_q;
  wire wr_hyst = wr_dat & (sel == tac_pkg::PTR_HYST_SET);
  wire wr_otemp = wr_dat & (sel == tac_pkg::PTR_OTEMP_SET);
  wire pin_mode = sec_q[tac_pkg::SEC_PIN_MODE_BIT];
  wire shutdown = cfg_q[tac_pkg::CFG_SHDN_BIT];

  // pointer and byte-position tracking
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ptr_q <= 8'h00;
      wbyte_q <= 1'b0;
      rbyte_q <= 1'b0;
    end else if (CE_I) begin
      if (wr_ptr) begin
        ptr_q <= WR_DATA_I;
      end
      // each new access and each pointer load restarts at the msb
      wbyte_q <= (acc_begin || wr_ptr) ? 1'b0 : (wbyte_q | wr_dat);
      rbyte_q <= (acc_begin || wr_ptr) ? 1'b0 : (rbyte_q ^ RD_REQ_I);
    end
  end

  // writable registers: msb byte then optional lsb byte
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_q <= tac_pkg::OPER_CFG_RST;
      sec_q <= tac_pkg::SEC_CFG_RST;
      hyst_q <= tac_pkg::HYST_SET_RST;
      otemp_q <= tac_pkg::OTEMP_SET_RST;
    end else if (CE_I) begin
      if (wr_cfg) begin
        cfg_q <= WR_DATA_I;
      end
      if (wr_sec) begin
        sec_q <= {WR_DATA_I[7:6], 6'h00};
      end
      if (wr_hyst && !wbyte_q) begin
        hyst_q[8:1] <= WR_DATA_I;
      end else if (wr_hyst) begin
        hyst_q[0] <= WR_DATA_I[7];
      end
      if (wr_otemp && !wbyte_q) begin
        otemp_q[8:1] <= WR_DATA_I;
      end else if (wr_otemp) begin
        otemp_q[0] <= WR_DATA_I[7];
      end
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [15:0] rd_word; // selected register, left justified
  always_comb begin
    case (sel)
      tac_pkg::PTR_TEMP_RESULT: rd_word = {temp_res_q, 6'h00};
      tac_pkg::PTR_OPER_CFG: rd_word = {cfg_q, 8'h00};
      tac_pkg::PTR_HYST_SET: rd_word = {hyst_q, 7'h00};
      tac_pkg::PTR_OTEMP_SET: rd_word = {otemp_q, 7'h00};
      tac_pkg::PTR_VOLT_RESULT: rd_word = {volt_res_q, 6'h00};
      tac_pkg::PTR_SEC_CFG: rd_word = {sec_q, 8'h00};
      default: rd_word = 16'h0000; // unused codes read zero
    endcase
  end

  // byte out one cycle after the request; 8-bit registers give msb only
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RD_DATA_O <= 8'h00;
      RD_VALID_O <= 1'b0;
    end else if (CE_I) begin
      RD_VALID_O <= RD_REQ_I;
      if (RD_REQ_I) begin
        RD_DATA_O <= rbyte_q ? rd_word[7:0] : rd_word[15:8];
      end
    end
  end

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  tac_pkg::tac_state_t state_q;
  logic [15:0] cnt_q; // delay / conversion cycle counter
  logic [15:0] auto_q; // automatic interval counter
  logic [2:0] chan_q; // channel latched at conversion start
  logic done_q; // one-cycle conversion end pulse

  wire chan_is_temp = (cfg_q[7:5] == tac_pkg::CHAN_TEMP);
  wire [15:0] conv_len = chan_is_temp ? 16'(tac_pkg::TEMP_CONV_CYC) : 16'(tac_pkg::VOLT_CONV_CYC);
  wire auto_hit = ~pin_mode & ~shutdown & (auto_q == 16'(AUTO_PERIOD - 1));
  wire acc_trig = ~pin_mode & ~shutdown & acc_end;
  wire pin_trig = start_fall & ~shutdown;
  wire conv_last = (state_q == tac_pkg::ST_CONV) & (cnt_q == 16'h0000);

  // state machine; triggers during a conversion are dropped
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= tac_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      chan_q <= tac_pkg::CHAN_TEMP;
      done_q <= 1'b0;
    end else if (CE_I) begin
      done_q <= conv_last;
      case (state_q)
        tac_pkg::ST_IDLE: begin
          if (pin_trig || auto_hit) begin
            state_q <= tac_pkg::ST_CONV;
            cnt_q <= conv_len - 16'h0001;
            chan_q <= cfg_q[7:5];
          end else if (acc_trig) begin
            state_q <= tac_pkg::ST_DELAY;
            cnt_q <= 16'(tac_pkg::HOLD_DELAY_CYC - 1);
          end
        end
        tac_pkg::ST_DELAY: begin
          if (cnt_q == 16'h0000) begin
            state_q <= tac_pkg::ST_CONV;
            cnt_q <= conv_len - 16'h0001;
            chan_q <= cfg_q[7:5];
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        tac_pkg::ST_CONV: begin
          if (cnt_q == 16'h0000) begin
            state_q <= tac_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= tac_pkg::ST_IDLE;
      endcase
    end
  end

  // automatic interval restarts with the oscillator after each access
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      auto_q <= 16'h0000;
    end else if (CE_I) begin
      auto_q <= (pin_mode || shutdown || acc_end || auto_hit) ? 16'h0000 : auto_q + 16'h0001;
    end
  end

  // result capture: temperature channel writes only temperature_result, every other channel voltage_conversion_result
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      temp_res_q <= 10'h000;
      volt_res_q <= 10'h000;
    end else if (CE_I && conv_last) begin
      if (chan_q == tac_pkg::CHAN_TEMP) begin
        temp_res_q <= ADC_CODE_I;
      end else begin
        volt_res_q <= ADC_CODE_I;
      end
    end
  end

  // analog controls follow the state; master owns acquisition spacing
  assign TRACK_HOLD_O = (state_q == tac_pkg::ST_CONV);
  assign CONV_BUSY_O = (state_q == tac_pkg::ST_CONV);
  assign REF_AMP_ON_O = (state_q == tac_pkg::ST_CONV) & refgnd_sync_q[1];
  assign INT_REF_EN_O = refgnd_sync_q[1];
  assign CHANNEL_O = (state_q == tac_pkg::ST_CONV) ? chan_q : cfg_q[7:5];

  // ************************************************************
  // over-temperature indicator
  // ************************************************************
  logic [2:0] fault_q; // consecutive over-limit count
  logic [2:0] clear_q; // consecutive under-hysteresis count
  logic oti_q; // indicator active
  logic [2:0] fq_need; // faults required

  // fault queue depth
  always_comb begin
    case (cfg_q[tac_pkg::CFG_FQ_LSB +: 2])
      2'b00: fq_need = 3'd1;
      2'b01: fq_need = 3'd2;
      2'b10: fq_need = 3'd4;
      default: fq_need = 3'd6;
    endcase
  end

  // 9 msbs of the signed code against the signed setpoints
  wire temp_done = done_q & (chan_q == tac_pkg::CHAN_TEMP);
  wire over = $signed(temp_res_q[9:1]) >= $signed(otemp_q);
  wire under = $signed(temp_res_q[9:1]) < $signed(hyst_q);
  wire int_mode = cfg_q[tac_pkg::CFG_INT_BIT];

  // comparator: clears below hysteresis; interrupt: clears on a read
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fault_q <= 3'd0;
      clear_q <= 3'd0;
      oti_q <= 1'b0;
    end else if (CE_I) begin
      if (temp_done) begin
        fault_q <= over ? ((fault_q == 3'd7) ? fault_q : fault_q + 3'd1) : 3'd0;
        clear_q <= under ? ((clear_q == 3'd7) ? clear_q : clear_q + 3'd1) : 3'd0;
      end
      // a new trip in the same cycle as a read clear wins
      if (temp_done && over && ({1'b0, fault_q} + 4'h1 >= {1'b0, fq_need})) begin
        oti_q <= 1'b1;
      end else if (int_mode && RD_REQ_I) begin
        oti_q <= 1'b0;
      end else if (!int_mode && temp_done && under && ({1'b0, clear_q} + 4'h1 >= {1'b0, fq_need})) begin
        oti_q <= 1'b0;
      end
    end
  end

  // active high polarity releases the pin when active
  assign OTI_OUT_O = 1'b0;
  assign OTI_OE_N_O = cfg_q[tac_pkg::CFG_POL_BIT] ? oti_q : ~oti_q;

  // ************************************************************
  // assertions
  // ************************************************************
  logic [15:0] conv_age_q; // cycles spent in conversion
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      conv_age_q <= 16'h0000;
    end else if (CE_I) begin
      conv_age_q <= (state_q == tac_pkg::ST_CONV) ? conv_age_q + 16'h0001 : 16'h0000;
    end
  end

  a_pin_start_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && pin_trig && state_q == tac_pkg::ST_IDLE) |=> TRACK_HOLD_O)
    else $error("start pin edge did not enter hold");
  a_access_delay: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && acc_trig && state_q == tac_pkg::ST_IDLE && !auto_hit && !pin_trig) |=>
      (!TRACK_HOLD_O && state_q == tac_pkg::ST_DELAY))
    else $error("access end did not start the hold delay");
  a_access_conv: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (state_q == tac_pkg::ST_DELAY && cnt_q == 16'h0000 && CE_I) |=> TRACK_HOLD_O)
    else $error("delay did not end in a conversion");
  a_conv_length: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && conv_last) |-> (conv_age_q + 16'h0001 ==
      ((chan_q == tac_pkg::CHAN_TEMP) ? 16'(tac_pkg::TEMP_CONV_CYC) : 16'(tac_pkg::VOLT_CONV_CYC))))
    else $error("conversion length wrong for channel");
  a_ref_amp: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    REF_AMP_ON_O |-> (TRACK_HOLD_O && INT_REF_EN_O))
    else $error("reference amplifier on outside a conversion");
  a_ptr_load: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && wr_ptr) |=> (ptr_q == $past(WR_DATA_I)))
    else $error("first written byte not taken as pointer");
  a_temp_read: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && RD_REQ_I && rbyte_q && sel == tac_pkg::PTR_TEMP_RESULT) |=>
      (RD_DATA_O[5:0] == 6'h00 && RD_VALID_O))
    else $error("temperature low bits not zero");
  a_shutdown_idle: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (shutdown && state_q == tac_pkg::ST_IDLE) |=> !TRACK_HOLD_O)
    else $error("conversion started in shutdown");
  a_result_route: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && conv_last && chan_q != tac_pkg::CHAN_TEMP) |=> $stable(temp_res_q))
    else $error("voltage conversion changed temperature result");
  a_fault_trip: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (CE_I && !oti_q && !(temp_done && over && {1'b0, fault_q} + 4'h1 >= {1'b0, fq_need})) |=> !oti_q)
    else $error("indicator tripped before the fault queue filled");

  c_pin_conv: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) pin_trig ##1 TRACK_HOLD_O);
  c_access_conv: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    state_q == tac_pkg::ST_DELAY ##1 state_q == tac_pkg::ST_CONV);
  c_auto_conv: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) auto_hit);
  c_oti_trip: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) !oti_q ##1 oti_q);
endmodule

// file: test/tac_master_model.sv
// tac_master_model: bus master model driving the register access port
module tac_master_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic acc_o,
  output logic wr_valid_o,
  output logic wr_first_o,
  output logic [7:0] wr_data_o,
  output logic rd_req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // idle levels and access tasks
  // ************************************************************
  // everything changes just after a falling edge, away from the sampling edge
  initial begin
    acc_o = 1'b0;
    wr_valid_o = 1'b0;
    wr_first_o = 1'b0;
    wr_data_o = 8'h00;
    rd_req_o = 1'b0;
  end

  // one write access: pointer byte first, then n data bytes back to back
  task automatic send(input logic [2:0] ptr, input int n, input logic [7:0] b0, input logic [7:0] b1);
    @(negedge clk_i) acc_o = 1'b1;
    @(negedge clk_i) wr_valid_o = 1'b1;
    wr_first_o = 1'b1;
    wr_data_o = {5'h00, ptr};
    if (n > 0) begin
      @(negedge clk_i) wr_first_o = 1'b0;
      wr_data_o = b0;
    end
    if (n > 1) begin
      @(negedge clk_i) wr_data_o = b1;
    end
    // valid and access drop together, the access end follows the last byte
    @(negedge clk_i) wr_valid_o = 1'b0;
    wr_first_o = 1'b0;
    acc_o = 1'b0;
  endtask

  // one read access of two bytes; the answer stands one cycle after the request
  task automatic fetch(output logic [7:0] hi, output logic [7:0] lo, output logic v);
    @(negedge clk_i) acc_o = 1'b1;
    @(negedge clk_i) rd_req_o = 1'b1;
    @(negedge clk_i) rd_req_o = 1'b0;
    hi = rd_data_i;
    v = rd_valid_i;
    @(negedge clk_i) rd_req_o = 1'b1;
    @(negedge clk_i) rd_req_o = 1'b0;
    lo = rd_data_i;
    v = v & rd_valid_i;
    @(negedge clk_i) acc_o = 1'b0;
  endtask
endmodule

// file: test/tac_core_tb.sv
// tac_core_tb: self-checking bench for the conversion sequencer and register bank
module tac_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // clock, reset, pins
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_n = 1'b1; // start pin idles high
  logic ref_gnd = 1'b1; // reference pin grounded
  logic ce = 1'b1; // clock enable, dropped once
  logic [9:0] adc_code = 10'h064; // +25 C
  logic acc, wr_valid, wr_first, rd_req, rd_valid, hold, busy, amp, int_ref, over_temp_indicator, oti_oe_n;
  logic [7:0] wr_data, rd_data;
  logic [2:0] chan;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int d;

  always #4 clk = ~clk;

  tac_core uut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CONVERSION_START_N_I(start_n),
    .REFERENCE_INPUT_GND_I(ref_gnd), .ACC_ACTIVE_I(acc), .WR_VALID_I(wr_valid), .WR_FIRST_I(wr_first),
    .WR_DATA_I(wr_data), .RD_REQ_I(rd_req), .ADC_CODE_I(adc_code), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .TRACK_HOLD_O(hold), .CONV_BUSY_O(busy), .REF_AMP_ON_O(amp),
    .INT_REF_EN_O(int_ref), .CHANNEL_O(chan), .OTI_OUT_O(over_temp_indicator), .OTI_OE_N_O(oti_oe_n));

  tac_master_model m (.clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .acc_o(acc),
    .wr_valid_o(wr_valid), .wr_first_o(wr_first), .wr_data_o(wr_data), .rd_req_o(rd_req));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic complete_run();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // pointer write then two-byte read of the selected register
  task automatic rd(input logic [2:0] ptr, input logic [7:0] eh, input logic [7:0] el);
    logic [7:0] h, l;
    logic v;
    m.send(ptr, 0, 8'h00, 8'h00);
    m.fetch(h, l, v);
    chk(16'(v), 16'h0001);
    chk({h, l}, {eh, el});
  endtask

  // waits for hold, gives the wait, checks reference amp and hold length
  task automatic conv(input int len, input logic exp_amp, output int wait_n);
    int n;
    n = 0;
    while (hold !== 1'b1 && n < 1000) begin
      @(negedge clk) n++;
    end
    wait_n = n;
    chk(16'(amp), 16'(exp_amp));
    chk(16'(busy), 16'h0001);
    n = 0;
    while (hold === 1'b1 && n < 5000) begin
      @(negedge clk) n++;
    end
    chk(16'(n), 16'(len));
  endtask

  // hang guard, the whole run needs about 18000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // auto mode: one access, delay then a temperature conversion
    m.send(3'h1, 0, 8'h00, 8'h00);
    conv(3750, 1'b1, d);
    chk(16'(d >= 375 && d <= 378), 16'h0001);
    repeat (50) @(negedge clk);
    rd(3'h0, 8'h19, 8'h00);
    rd(3'h1, 8'h00, 8'h00);
    // pin mode, let the pending auto conversion drain
    m.send(3'h5, 1, 8'h80, 8'h00);
    repeat (4200) @(negedge clk);
    rd(3'h5, 8'h80, 8'h00);
    // voltage channel four through the start pin
    m.send(3'h1, 1, 8'h9A, 8'h00);
    rd(3'h1, 8'h9A, 8'h00);
    chk(16'(chan), 16'h0004);
    adc_code = 10'h2C5;
    start_n = 1'b0;
    conv(1875, 1'b1, d);
    start_n = 1'b1;
    repeat (50) @(negedge clk);
    rd(3'h4, 8'hB1, 8'h40);
    rd(3'h0, 8'h19, 8'h00);
    // setpoint keeps nine bits, result register ignores writes
    m.send(3'h3, 2, 8'h12, 8'hFF);
    rd(3'h3, 8'h12, 8'h80);
    m.send(3'h0, 1, 8'h55, 8'h00);
    rd(3'h0, 8'h19, 8'h00);
    // clock enable low: a configuration write is lost
    ce = 1'b0;
    m.send(3'h1, 1, 8'h55, 8'h00);
    ce = 1'b1;
    rd(3'h1, 8'h9A, 8'h00);
    // external reference: no internal amp during a temperature conversion
    ref_gnd = 1'b0;
    m.send(3'h1, 1, 8'h00, 8'h00);
    chk(16'(int_ref), 16'h0000);
    adc_code = 10'h3FF;
    start_n = 1'b0;
    conv(3750, 1'b0, d);
    start_n = 1'b1;
    repeat (50) @(negedge clk);
    rd(3'h0, 8'hFF, 8'hC0);
    rd(3'h4, 8'hB1, 8'h40);
    // over-temperature trip: 25 C result against a 0.5 C setpoint
    m.send(3'h3, 1, 8'h00, 8'h00);
    chk(16'(oti_oe_n), 16'h0001);
    adc_code = 10'h064;
    start_n = 1'b0;
    conv(3750, 1'b0, d);
    start_n = 1'b1;
    repeat (50) @(negedge clk);
    chk(16'(oti_oe_n), 16'h0000);
    chk(16'(over_temp_indicator), 16'h0000);
    // shutdown blocks the start pin
    m.send(3'h1, 1, 8'h01, 8'h00);
    start_n = 1'b0;
    repeat (20) @(negedge clk);
    chk(16'(hold), 16'h0000);
    start_n = 1'b1;
    complete_run();
  end
endmodule
